// File: rtl/clkdiv_cfg.svh
// register map, reset values, field positions and source indices
`ifndef CLKDIV_CFG_SVH
`define CLKDIV_CFG_SVH

`define ADDR_OUTCLK_SOURCE   8'h46
`define ADDR_OUTCLK_DIVIDER  8'h47
`define ADDR_SAR_SETUP       8'h49

`define RST_OUTCLK_SOURCE    3'h0
`define RST_OUTCLK_DIVIDER   8'h01
`define RST_SAR_SETUP        8'h00

`define OUTCLK_EN_BIT        7
`define CONV_FREQ_MSB        7
`define CONV_FREQ_LSB        6
`define CONV_SRC_AUTO_BIT    5
`define CONV_SRC_PICK_BIT    4
`define CONV_EN_AUTO_BIT     3
`define CONV_MAN_ON_BIT      2
`define CONV_MAN_RATIO_MSB   1

`define SRC_LAST_VALID       3'h5
`define SRC_NONE             3'h7
`define SRC_OSC              3'h4
`define SRC_CONV_AUDIO       3'h6
`define DIV_BY_128           8'h80
`define FREQ_CODE_12M        2'h3

`endif

// File: rtl/clkdiv_pkg.sv
// shared types of the clock output and converter clock logic
package clkdiv_pkg;

  typedef logic [7:0] ratio_t;

  // converter clock frequency modes
  typedef enum logic [1:0] {
    FREQ_6M   = 2'h0,
    FREQ_3M   = 2'h1,
    FREQ_1M5  = 2'h2,
    FREQ_12M  = 2'h3
  } conv_freq_t;

endpackage : clkdiv_pkg

// File: rtl/div_if.sv
// control and result signals between the top and one edge divider
`timescale 1ns/100ps
interface div_if;
  logic                 run_req;
  clkdiv_pkg::ratio_t   ratio;
  logic                 src_level;
  logic                 src_rise;
  logic                 active;
  logic                 div_out;

  modport ctl (output run_req, ratio, src_level, src_rise, input active, div_out);
  modport div (input run_req, ratio, src_level, src_rise, output active, div_out);
endinterface : div_if

// File: rtl/edge_divider.sv
// divides a synchronised source clock by counting its rising edges
`timescale 1ns/100ps
module edge_divider (
  input wire logic ref_clk,  // system clock
  input wire logic rstn,     // sync reset, active low
  div_if.div       d         // control and divided output
);

  logic [6:0] count;
  logic       hi_q;
  logic       next_active;
  logic [6:0] next_count;
  logic [7:0] half;

  // start and stop only at a period boundary, so no short pulse
  always_comb begin
    next_active = d.active;
    next_count  = count;
    half        = 8'((9'(d.ratio) + 9'h001) >> 1);
    if (d.src_rise) begin
      if (!d.active || (8'(count) >= 8'(d.ratio - 8'h01))) begin
        next_count  = 7'h00;
        next_active = d.run_req;
      end else begin
        next_count = count + 7'h01;
      end
    end
  end

  // counter, run state and registered output
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count    <= 7'h00;
      d.active <= 1'b0;
      hi_q     <= 1'b0;
      d.div_out <= 1'b0;
    end else begin
      count    <= next_count;
      d.active <= next_active;
      if (d.src_rise) begin
        hi_q <= next_active && ({1'b0, next_count} < half);
      end
      // divide by one passes whole source phases only; the next run state
      // gates it so that starting or stopping leaves no runt pulse
      d.div_out <= (d.ratio == 8'h01) ? (next_active && d.src_level) : hi_q;
    end
  end

  AST_STOPPED_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
    d.div_out |-> d.active || $past(d.active))
    else $error("divided output high while divider stopped");

endmodule : edge_divider

// File: rtl/clock_output_conv_divider.sv
// clock output divider and converter clock generator with config regs
`timescale 1ns/100ps
`include "clkdiv_cfg.svh"

// How it works
// - the output divider starts only while its enable bit is set and stops at the end of a period once it clears.
// - divide field zero divides by 128; values 1 to 126 divide by themselves.
// - field 127 divides by 127; field resets to one.
// - frequency code picks about 6, 3, 1.5 or 12 MHz converter clock.
// - the 12 MHz code counts only when the oscillator feeds it directly.
// - source bit clear picks converter source from clock detection.
// - in manual source mode, pick bit chooses audio clock or oscillator.
// - enable-auto bit clear enables the converter divider automatically.
// - in manual enable mode, on bit turns the converter divider on or off.
// - manual mode divide field gives ratio 1, 2, 4 or 8.
// - configuration registers keep their values through sleep.
// - three-bit select picks output source; codes 6 and 7 reserved.
module clock_output_conv_divider (
  input  wire logic       ref_clk,             // 25 MHz system clock
  input  wire logic       rstn,                // sync reset, active low
  input  wire logic [7:0] reg_addr,            // register address
  input  wire logic       reg_wr,              // write strobe
  input  wire logic [7:0] reg_wdata,           // write data
  output logic      [7:0] reg_rdata,           // read data, registered
  input  wire logic       pll_clk,             // source 0
  input  wire logic       pri_bclk,            // source 1
  input  wire logic       sec_bclk,            // source 2
  input  wire logic       ctrl_clk,            // source 3
  input  wire logic       osc_clk,             // source 4
  input  wire logic       proc_clk,            // source 5
  input  wire logic       adc_dac_clk,         // converter audio clock
  input  wire logic       audio_clk_detected,  // detection result
  input  wire logic       conv_request,        // converters need a clock
  output logic            outclk,              // divided clock output
  output logic            outclk_running,      // output divider active
  output logic            conv_clk,            // converter clock
  output logic            conv_clk_running,    // converter divider active
  output logic            conv_freq_fallback   // 12 MHz code not honoured
);

  //--------------------------------------------------------------
  // source synchronisers
  //--------------------------------------------------------------
  logic [6:0] src_raw;
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] sync3;
  logic [6:0] src_stable;
  logic [6:0] src_stable_d;
  logic [6:0] src_rise;

  assign src_raw  = {adc_dac_clk, proc_clk, osc_clk, ctrl_clk, sec_bclk, pri_bclk, pll_clk};
  assign src_rise = src_stable & ~src_stable_d;

  // three-stage capture of each source pin
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync1        <= 7'h00;
      sync2        <= 7'h00;
      sync3        <= 7'h00;
      src_stable_d <= 7'h00;
    end else begin
      sync1        <= src_raw;
      sync2        <= sync1;
      sync3        <= sync2;
      src_stable_d <= src_stable;
    end
  end

  // a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_stable
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          src_stable[gi] <= 1'b0;
        end else if (sync2[gi] == sync3[gi]) begin
          src_stable[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // one bit of a source vector; the none code gives a quiet source
  function automatic logic src_bit(input logic [2:0] idx, input logic [6:0] vec);
    src_bit = (idx == `SRC_NONE) ? 1'b0 : vec[idx];
  endfunction : src_bit

  //--------------------------------------------------------------
  // configuration registers
  //--------------------------------------------------------------
  logic [2:0] outclk_source_select;
  logic       outclk_divider_enable;
  logic [6:0] outclk_divide_ratio;
  logic [7:0] sar_clock_setup;

  // writes only; nothing but rstn clears them, so sleep keeps them
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      outclk_source_select  <= `RST_OUTCLK_SOURCE;
      outclk_divider_enable <= 1'(`RST_OUTCLK_DIVIDER >> `OUTCLK_EN_BIT);
      outclk_divide_ratio   <= 7'(`RST_OUTCLK_DIVIDER);
      sar_clock_setup       <= `RST_SAR_SETUP;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_OUTCLK_SOURCE) begin
        outclk_source_select <= reg_wdata[2:0];
      end
      if (reg_addr == `ADDR_OUTCLK_DIVIDER) begin
        outclk_divider_enable <= reg_wdata[`OUTCLK_EN_BIT];
        outclk_divide_ratio   <= reg_wdata[6:0];
      end
      if (reg_addr == `ADDR_SAR_SETUP) begin
        sar_clock_setup <= reg_wdata;
      end
    end
  end

  // registered read-back, unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `ADDR_OUTCLK_SOURCE:  reg_rdata <= {5'h00, outclk_source_select};
        `ADDR_OUTCLK_DIVIDER: reg_rdata <= {outclk_divider_enable, outclk_divide_ratio};
        `ADDR_SAR_SETUP:      reg_rdata <= sar_clock_setup;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  //--------------------------------------------------------------
  // clock output divider
  //--------------------------------------------------------------
  div_if out_div ();
  logic [2:0] out_idx;

  // reserved select codes feed no source
  assign out_idx = (outclk_source_select > `SRC_LAST_VALID) ? `SRC_NONE
                                                            : outclk_source_select;
  assign out_div.src_level = src_bit(out_idx, src_stable);
  assign out_div.src_rise  = src_bit(out_idx, src_rise);
  assign out_div.run_req   = outclk_divider_enable;
  // zero means 128, every other value divides by itself
  assign out_div.ratio     = (outclk_divide_ratio == 7'h00) ? `DIV_BY_128
                                                            : {1'b0, outclk_divide_ratio};

  edge_divider u_out_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .d       (out_div)
  );

  //--------------------------------------------------------------
  // converter clock generator
  //--------------------------------------------------------------
  div_if conv_div ();
  clkdiv_pkg::conv_freq_t conv_clock_freq_mode;
  logic       conv_source_auto_off;
  logic       conv_source_manual_pick;
  logic       conv_enable_auto_off;
  logic       conv_divider_manual_on;
  logic [1:0] conv_divider_manual_ratio;
  logic [2:0] conv_idx;
  logic       osc_direct;
  logic [2:0] freq_log;
  logic [2:0] total_log;

  assign conv_clock_freq_mode = clkdiv_pkg::conv_freq_t'(
                                  sar_clock_setup[`CONV_FREQ_MSB:`CONV_FREQ_LSB]);
  assign conv_source_auto_off      = sar_clock_setup[`CONV_SRC_AUTO_BIT];
  assign conv_source_manual_pick   = sar_clock_setup[`CONV_SRC_PICK_BIT];
  assign conv_enable_auto_off      = sar_clock_setup[`CONV_EN_AUTO_BIT];
  assign conv_divider_manual_on    = sar_clock_setup[`CONV_MAN_ON_BIT];
  assign conv_divider_manual_ratio = sar_clock_setup[`CONV_MAN_RATIO_MSB:0];

  // source: detection result in auto, pick bit in manual
  assign conv_idx = conv_source_auto_off
                    ? (conv_source_manual_pick ? `SRC_OSC : `SRC_CONV_AUDIO)
                    : (audio_clk_detected ? `SRC_CONV_AUDIO : `SRC_OSC);
  assign osc_direct = conv_source_auto_off && conv_source_manual_pick;

  // frequency mode as a power of two below the 12 MHz reference
  always_comb begin
    unique case (conv_clock_freq_mode)
      clkdiv_pkg::FREQ_6M:  freq_log = 3'h1;
      clkdiv_pkg::FREQ_3M:  freq_log = 3'h2;
      clkdiv_pkg::FREQ_1M5: freq_log = 3'h3;
      clkdiv_pkg::FREQ_12M: freq_log = osc_direct ? 3'h0 : 3'h1;
    endcase
  end

  // manual ratio only counts with the manual source choice
  assign total_log = freq_log + (conv_source_auto_off ? {1'b0, conv_divider_manual_ratio}
                                                      : 3'h0);
  assign conv_div.ratio     = 8'h01 << total_log;
  assign conv_div.src_level = src_bit(conv_idx, src_stable);
  assign conv_div.src_rise  = src_bit(conv_idx, src_rise);
  assign conv_div.run_req   = conv_enable_auto_off ? conv_divider_manual_on
                                                   : conv_request;

  edge_divider u_conv_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .d       (conv_div)
  );

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  assign outclk           = out_div.div_out;
  assign outclk_running   = out_div.active;
  assign conv_clk         = conv_div.div_out;
  assign conv_clk_running = conv_div.active;

  // flags an unusable 12 MHz request
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conv_freq_fallback <= 1'b0;
    end else begin
      conv_freq_fallback <= (conv_clock_freq_mode == clkdiv_pkg::FREQ_12M) && !osc_direct;
    end
  end

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_EN_GATES_RUN: assert property (!outclk_divider_enable && !outclk_running
                                     |=> !outclk_running)
    else $error("output divider started while disabled");
  AST_ZERO_IS_128: assert property (reg_wr && reg_addr == `ADDR_OUTCLK_DIVIDER
                                    && reg_wdata[6:0] == 7'h00
                                    |=> out_div.ratio == 8'h80)
    else $error("divide field zero did not give 128");
  AST_RATIO_127: assert property (outclk_divide_ratio == 7'h7F
                                  |-> out_div.ratio == 8'h7F)
    else $error("divide field 127 did not give 127");
  AST_RESET_ONE: assert property ($rose(rstn) |-> outclk_divide_ratio == 7'h01)
    else $error("divide field not one after reset");
  AST_FREQ_12M: assert property (conv_div.ratio == 8'h01 |-> osc_direct)
    else $error("12 MHz mode used without direct oscillator");
  AST_FREQ_6M: assert property (conv_clock_freq_mode == clkdiv_pkg::FREQ_6M
                                && !conv_source_auto_off |-> conv_div.ratio == 8'h02)
    else $error("6 MHz mode wrong ratio");
  AST_AUTO_SRC: assert property (!conv_source_auto_off && audio_clk_detected
                                 |-> conv_idx == 3'h6)
    else $error("auto source ignored detection");
  AST_MAN_SRC: assert property (conv_source_auto_off && conv_source_manual_pick
                                |-> conv_idx == 3'h4)
    else $error("manual pick ignored");
  AST_AUTO_EN: assert property (!conv_enable_auto_off && !conv_request
                                && !conv_clk_running |=> !conv_clk_running)
    else $error("converter divider ran without request");
  AST_MAN_EN: assert property (conv_enable_auto_off && !conv_divider_manual_on
                               && !conv_clk_running |=> !conv_clk_running)
    else $error("converter divider ran while manually off");
  AST_MAN_DIV: assert property (conv_source_auto_off
                                && conv_divider_manual_ratio == 2'h3
                                && conv_clock_freq_mode == clkdiv_pkg::FREQ_1M5
                                |-> conv_div.ratio == 8'h40)
    else $error("manual ratio not applied");
  AST_RESERVED_QUIET: assert property (outclk_source_select > 3'h5 && !outclk
                                       |=> !outclk)
    else $error("reserved source produced a clock");
  AST_KEEP_CFG: assert property (!reg_wr |=> $stable(sar_clock_setup))
    else $error("config changed without a write");

  COV_OUTCLK_RUN: cover property (outclk_running && $rose(outclk));
  COV_CONV_RUN:   cover property (conv_clk_running && $rose(conv_clk));
  COV_FALLBACK:   cover property ($rose(conv_freq_fallback));
  COV_STOP:       cover property ($fell(outclk_running));

endmodule : clock_output_conv_divider

// File: test/clk_source_model.sv
// host side model: source clocks for the dividers, stoppable for sleep
`timescale 1ns/100ps
module clk_source_model (
  input  wire logic       run,      // clocks toggle only while high
  output logic      [5:0] src_clk,  // output divider sources 0..5
  output logic            audio_clk // converter audio clock
);
  // ----
  // clock generation
  // ----
  // distinct half periods of 3+k cycles so a wrong source shows in the rate
  for (genvar k = 0; k < 6; k++) begin : g_src
    initial begin
      src_clk[k] = 1'b0;
      #13;
      forever begin
        #((3 + k) * 40);
        src_clk[k] = run ? ~src_clk[k] : 1'b0;
      end
    end
  end

  // audio clock, half period 10 cycles; rests low while stopped
  initial begin
    audio_clk = 1'b0;
    #13;
    forever begin
      #400;
      audio_clk = run ? ~audio_clk : 1'b0;
    end
  end
endmodule : clk_source_model

// File: test/clock_output_and_sar_clock_divider_test.sv
// self-checking bench for the clock output and converter clock dividers
`timescale 1ns/100ps
module clock_output_and_sar_clock_divider_test;
  localparam int SLEEP_WAIT = 150; // scaled waits around the clock stop
  localparam int WAKE_WAIT  = 40;
  logic       ref_clk, rstn, reg_wr, run, det, creq, outclk, o_run;
  logic       conv_clk, c_run, fallback, audio_clk, mon_sel, meas_req, s, s_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  logic [5:0] src_clk;
  int         mismatches, tests_run, cyc, t_rise, t_fall, armed, ep, eh, w;
  int         seed = 32'h8d647a1e;
  int         exp_q[$];
  logic [7:0] ratio_list [5] = '{8'h01, 8'h03, 8'h7F, 8'h00, 8'h7E};

  clk_source_model clk_source_model_inst (.run(run), .src_clk(src_clk), .audio_clk(audio_clk));
  clock_output_conv_divider clock_output_conv_divider_inst (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_clk(src_clk[0]),
    .pri_bclk(src_clk[1]), .sec_bclk(src_clk[2]), .ctrl_clk(src_clk[3]),
    .osc_clk(src_clk[4]), .proc_clk(src_clk[5]), .adc_dac_clk(audio_clk),
    .audio_clk_detected(det), .conv_request(creq), .outclk(outclk),
    .outclk_running(o_run), .conv_clk(conv_clk), .conv_clk_running(c_run),
    .conv_freq_fallback(fallback));

  // ----
  // clock and tasks
  // ----
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  task automatic end_sim;
    $display("counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    chk(reg_rdata, exp, "register read");
  endtask : rd

  // note expected period and high time in ref cycles, then wait for the monitor
  // monitor flags change by nba, so the monitor sees them one edge later, and
  // a switched monitor input settles before arming
  task automatic per(input logic which, input int n, input int half);
    mon_sel <= which;
    @(negedge ref_clk);
    exp_q.push_back(n * 2 * half);
    exp_q.push_back((n == 1) ? half : ((n + 1) / 2) * 2 * half);
    meas_req <= 1'b1;
    for (w = 0; w < 5000 && exp_q.size() > 0; w++) @(negedge ref_clk);
    if (exp_q.size() > 0) begin
      chk(8'h01, 8'h00, "no clock edges seen");
      exp_q.delete();
    end
    meas_req <= 1'b0;
    @(negedge ref_clk);
  endtask : per

  // selected divider and its running flag must rest low
  task automatic quiet(input logic which);
    repeat (64) begin
      @(negedge ref_clk);
      chk({7'h00, which ? (conv_clk | c_run) : (outclk | o_run)}, 8'h00, "clock not quiet");
    end
  endtask : quiet

  // ----
  // monitor: measures one rise-to-rise period against the oldest note
  // ----
  // sampled at the falling edge, where the registered outputs have settled
  always @(negedge ref_clk) begin
    cyc++;
    s = mon_sel ? conv_clk : outclk;
    if (!meas_req) armed = 0;
    if (s && !s_d) begin
      if (meas_req && armed >= 2 && exp_q.size() >= 2) begin
        ep = exp_q.pop_front();
        eh = exp_q.pop_front();
        tests_run++;
        if (cyc - t_rise != ep || t_fall - t_rise != eh) begin
          mismatches++;
          $display("mismatch at %0t: period %0d high %0d", $time, cyc - t_rise, t_fall - t_rise);
        end
      end
      armed = meas_req ? armed + 1 : 0;
      t_rise = cyc;
    end
    if (!s && s_d) t_fall = cyc;
    s_d = s;
  end

  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  // ----
  // main sequence
  // ----
  initial begin
    {rstn, reg_wr, det, creq, mon_sel, meas_req, s_d} = '0;
    {reg_addr, reg_wdata} = '0;
    run = 1'b1;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    rd(8'h46, 8'h00);
    rd(8'h47, 8'h01);
    rd(8'h49, 8'h00);
    wr(8'h46, 8'hFF);
    rd(8'h46, 8'h07);
    wr(8'h50, 8'hAA);
    rd(8'h50, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      wr(8'h46, 8'(k));
      wr(8'h47, 8'h82);
      per(1'b0, 2, 3 + k);
    end
    $display("test sources done");
    wr(8'h46, 8'h00);
    foreach (ratio_list[i]) begin
      r = ratio_list[i];
      wr(8'h47, 8'h80 | r);
      per(1'b0, (r == 8'h00) ? 128 : r, 3);
    end
    repeat (2) begin
      r = 8'($random(seed)) & 8'h7F;
      wr(8'h47, 8'h80 | r);
      per(1'b0, (r == 8'h00) ? 128 : r, 3);
    end
    wr(8'h47, 8'h03);
    repeat (800) @(negedge ref_clk);
    quiet(1'b0);
    wr(8'h46, 8'h06);
    wr(8'h47, 8'h82);
    repeat (100) @(negedge ref_clk);
    quiet(1'b0);
    wr(8'h46, 8'h07);
    quiet(1'b0);
    $display("test output divider done");
    for (int f = 0; f < 4; f++) begin
      wr(8'h49, 8'((f << 6) | 8'h3C | (3 - f)));
      per(1'b1, 1 << (((f == 3) ? 0 : f + 1) + 3 - f), 7);
      chk({7'h00, fallback}, 8'h00, "fallback set");
    end
    wr(8'h49, 8'hBF);
    per(1'b1, 64, 7);
    wr(8'h49, 8'hED);
    per(1'b1, 4, 10);
    chk({7'h00, fallback}, 8'h01, "fallback clear");
    wr(8'h49, 8'h38);
    repeat (300) @(negedge ref_clk);
    quiet(1'b1);
    creq = 1'b1;
    det = 1'b1;
    wr(8'h49, 8'h47);
    per(1'b1, 4, 10);
    det = 1'b0;
    per(1'b1, 4, 7);
    creq = 1'b0;
    repeat (300) @(negedge ref_clk);
    quiet(1'b1);
    $display("test converter done");
    wr(8'h46, 8'h01);
    wr(8'h47, 8'h85);
    repeat (SLEEP_WAIT) @(negedge ref_clk);
    run = 1'b0;
    repeat (WAKE_WAIT) @(negedge ref_clk);
    rd(8'h46, 8'h01);
    rd(8'h47, 8'h85);
    rd(8'h49, 8'h47);
    run = 1'b1;
    per(1'b0, 5, 4);
    $display("test sleep retention done");
    end_sim();
  end
endmodule : clock_output_and_sar_clock_divider_test
